// ==== src/rxcc_top.sv ====
// Purpose: receiver state control, sync detector gating, buffer protection and gain test bits
// Assumes: demodulator signals share clock_in; chip select arrives from a pin
// Notes:   registers are 8 bits wide in the low byte of each wishbone word
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps

// Operation
// [R1] basic mode: receive-on command enters receive only from off or pll-locked
// [R2] extended mode: auto-ack receive command accepted from off, pll-locked, auto-retry
// [R3] basic mode receives frames with just the receive-on command
// [R4] nonzero threshold: weak signals never start demodulation
// [R5] safe mode holds receive state until host finishes the frame read
// [R6] protection applies only to frames with valid check sequence
// [R7] disable bit set: stay in receive, detect no sync header
// [R8] disable bit 0 enables, 1 blocks new frames, reset value 0
// [R9] setting disable bit never aborts a frame in progress
// [R10] disable blocking ignores the threshold field value
// [R11] four-bit threshold field desensitizes in 3 dB steps
// [R12] nonzero N needs power above base level plus 3 dB times N minus 1
// [R13] threshold zero receives every valid frame regardless of strength
// [R14] gain bits always readable, act only with measurement unit enabled
// [R15] bit 5 selects normal or manual gain, freeze bit governs manual
// [R16] writing 1 to gain reset bit resets gain to maximum
// [R17] bit 3 switches off automatic gain, manual field then sets gain
// [R18] bit 2 freezes gain loop running state
// [R19] manual gain field: 0 max, 1 medium, 2 min, 3 reserved
// [R20] reserved gain bits 7 and 6 read zero, writes ignored
module rxcc_top
	import rxcc_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [9:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	input  wire logic        shr_detect_in,
	input  wire logic        frame_end_in,
	input  wire logic        fcs_valid_in,
	input  wire logic [7:0]  rssi_in,
	input  wire logic [7:0]  base_signal_level_in,
	input  wire logic        frame_read_mode_in,
	input  wire logic        sel_n_in,
	output logic             demod_start_out,
	output logic             rx_busy_out,
	output logic [4:0]       radio_state_out,
	output logic             buffer_protect_out,
	output rxcc_gain_t       gain_ctrl_out
);

	// register storage
	logic [7:0]  sync_q;
	logic [7:0]  gain_q;
	logic        safe_mode_q;
	logic        ext_mode_q;
	logic        meas_en_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	rxcc_state_t state_q;
	rxcc_state_t state_d;
	logic        protect_q;
	logic        protect_d;
	logic        demod_q;
	logic        sel_meta_q;
	logic        sel_sync_q;
	logic        sel_prev_q;
	logic        busy_q;
	rxcc_gain_t  gain_eff_q;

	// bus decode
	wire         wb_req      = wb_cyc_in & wb_stb_in & ~ack_q;
	wire         wr_lane0    = wb_req & wb_we_in & wb_sel_in[0];
	wire         hit_state   = (wb_adr_in == ADR_STATE);
	wire         hit_ctrl0   = (wb_adr_in == ADR_CTRL0);
	wire         hit_ctrl2   = (wb_adr_in == ADR_CTRL2);
	wire         hit_sync    = (wb_adr_in == ADR_SYNC);
	wire         hit_gain    = (wb_adr_in == ADR_GAIN);
	wire         wr_state    = wr_lane0 & hit_state;
	wire         wr_ctrl0    = wr_lane0 & hit_ctrl0;
	wire         wr_ctrl2    = wr_lane0 & hit_ctrl2;
	wire         wr_sync     = wr_lane0 & hit_sync;
	wire         wr_gain     = wr_lane0 & hit_gain;
	wire  [4:0]  cmd         = wr_state ? wb_dat_in[4:0] : CMD_NOP;
	wire  [7:0]  ctrl0_rd    = {7'h00, meas_en_q};
	wire  [7:0]  ctrl2_rd    = {safe_mode_q, 6'h00, ext_mode_q};

	// read mux, unmapped addresses read zero
	wire  [7:0]  rd_byte     = hit_state ? {3'h0, state_q} :
	                           hit_ctrl0 ? ctrl0_rd :
	                           hit_ctrl2 ? ctrl2_rd :
	                           hit_sync  ? sync_q :
	                           hit_gain  ? gain_q : 8'h00;

	// threshold compare: pass if level zero or rssi above base + 3*(N-1)
	wire  [3:0]  level       = sync_q[3:0];
	wire  [3:0]  level_m1    = level - 4'h1;
	wire  [8:0]  level_db    = 9'({3'h0, level_m1} * {4'h0, LEVEL_STEP});
	wire  [8:0]  thresh_db   = {1'b0, base_signal_level_in} + level_db;
	wire         level_pass  = (level == LEVEL_ZERO) | ({1'b0, rssi_in} > thresh_db); // R4 R11 R12 R13
	wire         path_dis    = sync_q[SYNC_DIS_BIT];
	wire         in_listen   = (state_q == ST_RX) | (state_q == ST_AACK);
	wire         in_busy     = (state_q == ST_BUSY_RX) | (state_q == ST_BUSY_AACK);
	wire         busy_d      = (state_d == ST_BUSY_RX) | (state_d == ST_BUSY_AACK);
	wire         detect_ok   = in_listen & shr_detect_in & ~path_dis & level_pass & ~protect_q; // R7 R8 R10

	// frame read finished: chip select rises during a frame-read transfer
	wire         read_done   = frame_read_mode_in & sel_sync_q & ~sel_prev_q; // R5
	wire         protect_set = in_busy & frame_end_in & safe_mode_q & fcs_valid_in; // R6

	// state transitions
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF, ST_PLL: begin
				if (cmd == CMD_OFF)
					state_d = ST_OFF;
				else if (cmd == CMD_PLL)
					state_d = ST_PLL;
				else if (cmd == CMD_RX && !ext_mode_q)
					state_d = ST_RX; // R1 R3
				else if (cmd == CMD_AACK && ext_mode_q)
					state_d = ST_AACK; // R2
				else if (cmd == CMD_ARET && ext_mode_q)
					state_d = ST_ARET;
			end
			ST_ARET: begin
				if (cmd == CMD_OFF)
					state_d = ST_OFF;
				else if (cmd == CMD_PLL)
					state_d = ST_PLL;
				else if (cmd == CMD_AACK && ext_mode_q)
					state_d = ST_AACK; // R2
			end
			ST_RX, ST_AACK: begin
				if (detect_ok)
					state_d = (state_q == ST_RX) ? ST_BUSY_RX : ST_BUSY_AACK;
				else if (protect_q)
					state_d = state_q; // R5
				else if (cmd == CMD_OFF)
					state_d = ST_OFF;
				else if (cmd == CMD_PLL)
					state_d = ST_PLL;
			end
			ST_BUSY_RX: begin
				if (frame_end_in)
					state_d = ST_RX; // R9
			end
			ST_BUSY_AACK: begin
				if (frame_end_in)
					state_d = ST_AACK; // R9
			end
			default: state_d = ST_OFF;
		endcase
	end

	// protection flag, a new set wins over a clear in the same cycle
	assign protect_d = protect_set | (protect_q & ~read_done); // R5 R6

	// bus slave: one-cycle ack, registered read data
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= wb_req;
			rdata_q <= wb_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// software registers
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_q      <= SYNC_RESET; // R8 R13
			gain_q      <= GAIN_RESET;
			safe_mode_q <= 1'b0;
			ext_mode_q  <= 1'b0;
			meas_en_q   <= 1'b0;
		end else begin
			if (wr_sync)
				sync_q <= wb_dat_in[7:0] & SYNC_MASK;
			if (wr_gain)
				gain_q <= wb_dat_in[7:0] & GAIN_MASK; // R14 R20
			if (wr_ctrl2) begin
				safe_mode_q <= wb_dat_in[CTRL2_SAFE];
				ext_mode_q  <= wb_dat_in[CTRL2_EXT];
			end
			if (wr_ctrl0)
				meas_en_q <= wb_dat_in[CTRL0_MEAS];
		end
	end

	// chip select pin synchroniser and edge history
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sel_meta_q <= 1'b1;
			sel_sync_q <= 1'b1;
			sel_prev_q <= 1'b1;
		end else begin
			sel_meta_q <= sel_n_in;
			sel_sync_q <= sel_meta_q;
			sel_prev_q <= sel_sync_q;
		end
	end

	// radio state, protection and demodulator start
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q   <= ST_OFF;
			protect_q <= 1'b0;
			demod_q   <= 1'b0;
			busy_q    <= 1'b0;
		end else begin
			state_q   <= state_d;
			protect_q <= protect_d;
			demod_q   <= detect_ok; // R4
			busy_q    <= busy_d; // R9
		end
	end

	// effective gain controls: stored bits only with measurement unit on
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gain_eff_q <= '0;
		end else begin
			if (meas_en_q) begin
				gain_eff_q.mode_sel    <= gain_q[GAIN_SEL_BIT]; // R15
				gain_eff_q.auto_off    <= gain_q[GAIN_OFF_BIT]; // R17
				gain_eff_q.freeze      <= gain_q[GAIN_SEL_BIT] & gain_q[GAIN_HLD_BIT]; // R15 R18
				gain_eff_q.manual_gain <= gain_q[GAIN_OFF_BIT] ? gain_q[1:0] : 2'h0; // R19
			end else begin
				gain_eff_q.mode_sel    <= GAIN_RESET[GAIN_SEL_BIT]; // R14
				gain_eff_q.auto_off    <= GAIN_RESET[GAIN_OFF_BIT];
				gain_eff_q.freeze      <= GAIN_RESET[GAIN_HLD_BIT];
				gain_eff_q.manual_gain <= GAIN_RESET[1:0];
			end
			gain_eff_q.gain_reset <= wr_gain & wb_dat_in[GAIN_RST_BIT] & meas_en_q; // R16
		end
	end

	// outputs straight from flops
	assign wb_ack_out         = ack_q;
	assign wb_dat_out         = rdata_q;
	assign demod_start_out    = demod_q;
	assign rx_busy_out        = busy_q;
	assign radio_state_out    = state_q;
	assign buffer_protect_out = protect_q;
	assign gain_ctrl_out      = gain_eff_q;

	// helper history for assertions
	logic [7:0]  rssi_prev_q;
	logic [8:0]  thresh_prev_q;
	logic [3:0]  level_prev_q;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rssi_prev_q   <= 8'h00;
			thresh_prev_q <= 9'h000;
			level_prev_q  <= 4'h0;
		end else begin
			rssi_prev_q   <= rssi_in;
			thresh_prev_q <= thresh_db;
			level_prev_q  <= level;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_rx_cmd_basic;
		wr_state && wb_dat_in[4:0] == CMD_RX && !ext_mode_q && (state_q == ST_OFF || state_q == ST_PLL);
	endsequence
	sequence s_enter_rx;
		##1 state_q == ST_RX;
	endsequence
	sequence s_frame_protected;
		protect_set ##1 protect_q;
	endsequence
	sequence s_frame_accepted;
		detect_ok ##1 (demod_start_out && rx_busy_out);
	endsequence

	a_rx_cmd_enter: assert property (s_rx_cmd_basic |-> s_enter_rx) // R1
		else $error("receive-on command did not enter receive");
	a_rx_cmd_refused: assert property (wr_state && wb_dat_in[4:0] == CMD_RX && state_q == ST_ARET
		|=> state_q == ST_ARET) // R1
		else $error("receive-on accepted from auto-retry state");
	a_aack_from_aret: assert property (wr_state && wb_dat_in[4:0] == CMD_AACK && ext_mode_q
		&& state_q == ST_ARET |=> state_q == ST_AACK) // R2
		else $error("auto-ack receive command not accepted");
	a_weak_no_demod: assert property (demod_start_out |-> level_prev_q == LEVEL_ZERO
		|| {1'b0, rssi_prev_q} > thresh_prev_q) // R4
		else $error("demodulation started below threshold");
	a_protect_holds: assert property (protect_q && !read_done |=> protect_q) // R5
		else $error("protection dropped without frame read");
	a_protect_set: assert property (protect_set |-> s_frame_protected) // R5 R6
		else $error("valid frame in safe mode not protected");
	a_protect_clear: assert property (read_done && !protect_set |=> !protect_q) // R5
		else $error("protection kept after frame read");
	a_protect_state: assert property (protect_q && in_listen && !shr_detect_in |=> $stable(state_q)) // R5
		else $error("receive state left while protected");
	a_bad_fcs_free: assert property (frame_end_in && !fcs_valid_in && !protect_q |=> !protect_q) // R6
		else $error("frame with bad check sequence protected");
	a_disable_blocks: assert property (path_dis && in_listen |=> !demod_start_out && !rx_busy_out) // R7
		else $error("sync header detected while path disabled");
	a_busy_keeps: assert property (rx_busy_out && !frame_end_in |=> rx_busy_out) // R9
		else $error("frame in progress aborted");
	a_gain_default: assert property (!meas_en_q [*2] |-> gain_ctrl_out == '0) // R14
		else $error("gain bits active without measurement unit");
	a_gain_reset_pulse: assert property (wr_gain && wb_dat_in[GAIN_RST_BIT] && meas_en_q
		|=> gain_ctrl_out.gain_reset ##1 !gain_ctrl_out.gain_reset) // R16
		else $error("gain reset not a single pulse");
	a_manual_gated: assert property (gain_ctrl_out.manual_gain != 2'h0 |-> gain_ctrl_out.auto_off) // R19
		else $error("manual gain applied with automatic gain on");
	a_reserved_zero: assert property (gain_q[7:6] == 2'h0 && sync_q[6:4] == 3'h0) // R20
		else $error("reserved bits not zero");
	a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) // R14
		else $error("bus ack longer than one cycle");

	// further receive path, command and gain checks
	a_frame_accept: assert property (in_listen && shr_detect_in && !path_dis && !protect_q && level_pass // R3 R8
		|-> s_frame_accepted)
		else $error("accepted sync header did not start a frame");
	a_zero_level: assert property (level == LEVEL_ZERO && in_listen && shr_detect_in && !path_dis // R13
		&& !protect_q |=> demod_start_out)
		else $error("threshold zero refused a sync header");
	a_ext_rejects_rx: assert property (wr_state && wb_dat_in[4:0] == CMD_RX && ext_mode_q // R1
		&& state_q != ST_RX |=> state_q != ST_RX)
		else $error("receive-on accepted in extended mode");
	a_aack_from_off: assert property (wr_state && wb_dat_in[4:0] == CMD_AACK && ext_mode_q // R2
		&& (state_q == ST_OFF || state_q == ST_PLL) |=> state_q == ST_AACK)
		else $error("auto-ack receive command not accepted from off");
	a_basic_no_aack: assert property (wr_state && wb_dat_in[4:0] == CMD_AACK && !ext_mode_q // R2
		&& (state_q == ST_OFF || state_q == ST_PLL) |=> state_q != ST_AACK)
		else $error("auto-ack receive entered in basic mode");
	a_disable_keeps: assert property (path_dis && in_listen && cmd == CMD_NOP |=> in_listen) // R7
		else $error("receive state left while path disabled");
	a_busy_ends: assert property (rx_busy_out && frame_end_in |=> !rx_busy_out) // R9
		else $error("frame end did not return to listening");
	a_demod_pulse: assert property (demod_start_out |=> !demod_start_out) // R4
		else $error("demodulation start longer than one cycle");
	a_gain_reset_gated: assert property (!meas_en_q |=> !gain_ctrl_out.gain_reset) // R14 R16
		else $error("gain reset without measurement unit");
	a_freeze_gated: assert property (gain_ctrl_out.freeze |-> gain_ctrl_out.mode_sel) // R15 R18
		else $error("gain freeze applied in normal gain mode");

endmodule : rxcc_top

// ==== src/rxcc_pkg.sv ====
// Purpose: shared constants and types of the receiver control and configuration block
// Assumes: 8-bit registers on a 32-bit classic wishbone bus, one word per register
// Notes:   register index times four gives the byte address
package rxcc_pkg;
	// register indices and byte addresses
	localparam logic [7:0]  IDX_STATE    = 8'h02;
	localparam logic [7:0]  IDX_CTRL0    = 8'h03;
	localparam logic [7:0]  IDX_CTRL2    = 8'h0c;
	localparam logic [7:0]  IDX_SYNC     = 8'h15;
	localparam logic [7:0]  IDX_GAIN     = 8'h3c;
	localparam logic [9:0]  ADR_STATE    = {IDX_STATE, 2'b00};
	localparam logic [9:0]  ADR_CTRL0    = {IDX_CTRL0, 2'b00};
	localparam logic [9:0]  ADR_CTRL2    = {IDX_CTRL2, 2'b00};
	localparam logic [9:0]  ADR_SYNC     = {IDX_SYNC, 2'b00};
	localparam logic [9:0]  ADR_GAIN     = {IDX_GAIN, 2'b00};
	// field positions
	localparam int          SYNC_DIS_BIT = 7;
	localparam int          CTRL2_SAFE   = 7;
	localparam int          CTRL2_EXT    = 0;
	localparam int          CTRL0_MEAS   = 0;
	localparam int          GAIN_SEL_BIT = 5;
	localparam int          GAIN_RST_BIT = 4;
	localparam int          GAIN_OFF_BIT = 3;
	localparam int          GAIN_HLD_BIT = 2;
	// reset values and masks
	localparam logic [7:0]  SYNC_RESET   = 8'h00;
	localparam logic [7:0]  GAIN_RESET   = 8'h00;
	localparam logic [7:0]  GAIN_MASK    = 8'h3f;
	localparam logic [7:0]  SYNC_MASK    = 8'h8f;
	localparam logic [3:0]  LEVEL_ZERO   = 4'h0;
	localparam logic [1:0]  LEVEL_STEP   = 2'h3;
	// state command codes
	localparam logic [4:0]  CMD_NOP      = 5'h00;
	localparam logic [4:0]  CMD_OFF      = 5'h08;
	localparam logic [4:0]  CMD_PLL      = 5'h09;
	localparam logic [4:0]  CMD_RX       = 5'h06;
	localparam logic [4:0]  CMD_AACK     = 5'h16;
	localparam logic [4:0]  CMD_ARET     = 5'h19;

	// radio states, read back from the state register
	typedef enum logic [4:0] {
		ST_OFF       = 5'h08,
		ST_PLL       = 5'h09,
		ST_RX        = 5'h06,
		ST_BUSY_RX   = 5'h01,
		ST_AACK      = 5'h16,
		ST_BUSY_AACK = 5'h11,
		ST_ARET      = 5'h19
	} rxcc_state_t;

	// effective gain controls handed to the gain loop
	typedef struct packed {
		logic       mode_sel;
		logic       gain_reset;
		logic       auto_off;
		logic       freeze;
		logic [1:0] manual_gain;
	} rxcc_gain_t;
endpackage : rxcc_pkg

// ==== tb/rxcc_host_model.sv ====
// Purpose: host side, reads a received frame over the serial port
// Assumes: one frame read per request
// Notes:   read mode stays up four cycles after chip select rises
`timescale 1ns/100ps
module rxcc_host_model (
	input  wire logic clock_in,
	input  wire logic read_req_in,
	output logic      sel_n_out,
	output logic      frame_read_mode_out,
	output logic      done_out
);
	// frame read: select low, release, then hold read mode
	initial begin
		sel_n_out = 1'b1;
		frame_read_mode_out = 1'b0;
		done_out = 1'b0;
		forever begin
			@(posedge clock_in);
			done_out <= 1'b0;
			if (read_req_in === 1'b1) begin
				frame_read_mode_out <= 1'b1;
				sel_n_out <= 1'b0;
				repeat (8) @(posedge clock_in);
				sel_n_out <= 1'b1;
				repeat (4) @(posedge clock_in);
				frame_read_mode_out <= 1'b0;
				done_out <= 1'b1;
				@(posedge clock_in);
				done_out <= 1'b0;
			end
		end
	end
endmodule : rxcc_host_model

// ==== tb/rxcc_top_tb_top.sv ====
// Purpose: self-checking bench of the receiver control block
// Assumes: host model drives chip select and read mode
// Notes:   one task per scenario, base level fixed at 0x20
`timescale 1ns/100ps
module rxcc_top_tb_top
	import rxcc_pkg::*;
;
	logic        clock_in = 1'b0, reset_n_in = 1'b0;
	logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic        shr = 1'b0, fend = 1'b0, fcs = 1'b0, rd_req = 1'b0;
	logic [9:0]  wb_adr = 10'h000;
	logic [31:0] wb_wdat = 32'h0, wb_dat_out, rd;
	logic [7:0]  rssi = 8'h00, base = 8'h20;
	logic        wb_ack_out, demod, busy, prot, sel_n, rmode, hdone;
	logic [4:0]  st;
	rxcc_gain_t  gain;
	int          errors = 0, n_compared = 0, gr_cnt = 0, g0;

	always #5 clock_in = ~clock_in;

	rxcc_top i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
		.wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'h1), .wb_dat_in(wb_wdat), .wb_dat_out(wb_dat_out),
		.wb_ack_out(wb_ack_out), .shr_detect_in(shr), .frame_end_in(fend), .fcs_valid_in(fcs), .rssi_in(rssi),
		.base_signal_level_in(base), .frame_read_mode_in(rmode), .sel_n_in(sel_n), .demod_start_out(demod),
		.rx_busy_out(busy), .radio_state_out(st), .buffer_protect_out(prot), .gain_ctrl_out(gain));
	rxcc_host_model i_host (.clock_in(clock_in), .read_req_in(rd_req), .sel_n_out(sel_n),
		.frame_read_mode_out(rmode), .done_out(hdone));

	// count gain reset pulses
	always @(posedge clock_in) if (gain.gain_reset === 1'b1) gr_cnt++;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one classic cycle, held until ack is sampled
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int i;
		@(posedge clock_in);
		wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_wdat <= {24'h0, d};
		for (i = 0; i < 20 && wb_ack_out !== 1'b1; i++) @(posedge clock_in);
		if (i == 20) errors++;
		rd = wb_dat_out;
		wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
	endtask : bus

	task rdchk(input logic [9:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rdchk

	task cmd(input logic [4:0] c, input logic [4:0] e);
		bus(1'b1, ADR_STATE, {3'b000, c});
		bus(1'b0, ADR_STATE, 8'h00);
		chk(rd, {27'h0, e});
		chk(st, e);
	endtask : cmd

	// one sync header, then a frame end if accepted
	task frm(input logic [7:0] r, input logic acc, input logic f);
		@(posedge clock_in);
		rssi <= r; shr <= 1'b1;
		@(posedge clock_in);
		shr <= 1'b0;
		#1 chk(demod, acc);
		chk(busy, acc);
		if (acc) begin
			@(posedge clock_in);
			fend <= 1'b1; fcs <= f;
			@(posedge clock_in);
			fend <= 1'b0;
			#1 chk(busy, 1'b0);
		end
	endtask : frm

	task t_reset;
		rdchk(ADR_SYNC, 8'h00);
		rdchk(ADR_GAIN, 8'h00);
		rdchk(10'h3fc, 8'h00);
		chk(st, ST_OFF);
	endtask : t_reset

	task t_gain;
		bus(1'b1, ADR_GAIN, 8'hff);
		rdchk(ADR_GAIN, 8'h3f);
		chk(gain, 6'h00);
		chk(gr_cnt, 0);
		bus(1'b1, ADR_CTRL0, 8'h01);
		repeat (2) @(posedge clock_in);
		chk(gain & 6'h2f, 6'h2f);
		g0 = gr_cnt;
		bus(1'b1, ADR_GAIN, 8'h10);
		repeat (3) @(posedge clock_in);
		chk(gr_cnt, g0 + 1);
		bus(1'b1, ADR_GAIN, 8'h04);
		repeat (2) @(posedge clock_in);
		chk(gain & 6'h2f, 6'h00);
		bus(1'b1, ADR_GAIN, 8'h29);
		repeat (2) @(posedge clock_in);
		chk(gain & 6'h2f, 6'h29);
		bus(1'b1, ADR_GAIN, 8'h0a);
		repeat (2) @(posedge clock_in);
		chk(gain & 6'h2f, 6'h0a);
		bus(1'b1, ADR_CTRL0, 8'h00);
		repeat (2) @(posedge clock_in);
		chk(gain, 6'h00);
		rdchk(ADR_GAIN, 8'h0a);
	endtask : t_gain

	task t_frames;
		cmd(CMD_AACK, ST_OFF);
		cmd(CMD_PLL, ST_PLL);
		cmd(CMD_RX, ST_RX);
		frm(8'h00, 1'b1, 1'b1);
		bus(1'b1, ADR_SYNC, 8'h02);
		frm(8'h23, 1'b0, 1'b1);
		frm(8'h24, 1'b1, 1'b1);
		bus(1'b1, ADR_SYNC, 8'h0f);
		frm(8'h4a, 1'b0, 1'b1);
		frm(8'h4b, 1'b1, 1'b1);
		rdchk(ADR_SYNC, 8'h0f);
	endtask : t_frames

	task t_disable;
		bus(1'b1, ADR_SYNC, 8'h81);
		frm(8'hff, 1'b0, 1'b0);
		rdchk(ADR_SYNC, 8'h81);
		bus(1'b1, ADR_SYNC, 8'h00);
		frm(8'h00, 1'b1, 1'b0);
		@(posedge clock_in);
		rssi <= 8'h40; shr <= 1'b1;
		@(posedge clock_in);
		shr <= 1'b0;
		bus(1'b1, ADR_SYNC, 8'h80);
		chk(busy, 1'b1);
		@(posedge clock_in);
		fend <= 1'b1; fcs <= 1'b1;
		@(posedge clock_in);
		fend <= 1'b0;
		#1 chk(st, ST_RX);
		frm(8'h40, 1'b0, 1'b0);
		bus(1'b1, ADR_SYNC, 8'h00);
	endtask : t_disable

	task t_safe;
		int i;
		bus(1'b1, ADR_CTRL2, 8'h80);
		frm(8'h10, 1'b1, 1'b0);
		chk(prot, 1'b0);
		frm(8'h10, 1'b1, 1'b1);
		chk(prot, 1'b1);
		frm(8'h10, 1'b0, 1'b0);
		cmd(CMD_PLL, ST_RX);
		@(posedge clock_in);
		rd_req <= 1'b1;
		for (i = 0; i < 40 && hdone !== 1'b1; i++) @(posedge clock_in);
		rd_req <= 1'b0;
		#1 chk(prot, 1'b0);
		frm(8'h10, 1'b1, 1'b0);
		bus(1'b1, ADR_CTRL2, 8'h00);
	endtask : t_safe

	task t_ext;
		bus(1'b1, ADR_CTRL2, 8'h01);
		cmd(CMD_OFF, ST_OFF);
		cmd(CMD_RX, ST_OFF);
		cmd(CMD_ARET, ST_ARET);
		cmd(CMD_RX, ST_ARET);
		cmd(CMD_AACK, ST_AACK);
		cmd(CMD_PLL, ST_PLL);
		cmd(CMD_AACK, ST_AACK);
		frm(8'h10, 1'b1, 1'b1);
		chk(st, ST_AACK);
	endtask : t_ext

	task test_done;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		repeat (6) @(posedge clock_in);
		reset_n_in <= 1'b1;
		t_reset;
		t_gain;
		t_frames;
		t_disable;
		t_safe;
		t_ext;
		test_done;
	end

	// watchdog
	initial begin
		repeat (20000) @(posedge clock_in);
		errors++;
		test_done;
	end
endmodule : rxcc_top_tb_top
